// *** src/qsf_pkg.sv ***
package qsf_pkg;

  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned COND_W = 10;

  // Register offsets on the plain register port.
  localparam logic [3:0] OFF_COND    = 4'h0;
  localparam logic [3:0] OFF_EVENT   = 4'h1;
  localparam logic [3:0] OFF_ENABLE  = 4'h2;
  localparam logic [3:0] OFF_FALL    = 4'h3;
  localparam logic [3:0] OFF_RISE    = 4'h4;
  localparam logic [3:0] OFF_PRESET  = 4'h5;
  localparam logic [3:0] OFF_IRQ_ST  = 4'h6;
  localparam logic [3:0] OFF_IRQ_MSK = 4'h7;

  // Implemented bit positions of the condition group.
  localparam int unsigned BIT_OVERVOLTAGE_TRIP       = 0;
  localparam int unsigned BIT_OVERCURRENT_TRIP       = 1;
  localparam int unsigned BIT_POWER_FAIL_OFF         = 2;
  localparam int unsigned BIT_CONST_POWER_MODE       = 3;
  localparam int unsigned BIT_OVERTEMP_TRIP          = 4;
  localparam int unsigned BIT_MASTER_SLAVE_PROTECT   = 5;
  localparam int unsigned BIT_EXTERNAL_PIN_SHUTDOWN  = 9;
  localparam logic [9:0]  COND_MASK = 10'h23f;

  // Interrupt status bits.
  localparam int unsigned IRQ_W          = 2;
  localparam int unsigned IRQ_BIT_EVENT  = 0;
  localparam int unsigned IRQ_BIT_SUMMARY = 1;

  localparam logic [9:0]  RST_MASK = 10'h000;
  localparam logic [15:0] RST_DATA = 16'h0000;
  localparam logic [1:0]  RST_IRQ  = 2'h0;

endpackage

// *** src/qsf_filter.sv ***
// What this block does
// - Falling-mask bit set: 1-to-0 change sets event.
// - Rising-mask bit set: 0-to-1 change sets event.
// - Both masks set: any change sets event.
// - Both masks clear: no change sets event.
// - Masks hold bits 0 to 5 and 9.
// - Falling mask reads back unchanged.
// - Rising mask reads back with no side effects.
// - Condition bits mapped to fixed positions.
// - Events latch; reading event register clears them.
// - Summary is OR of enabled event bits.
// - Preset clears the enable mask.
//
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/1ns
module qsf_filter
(
  input  wire logic                    core_clk,
  input  wire logic                    rst_n,
  input  wire logic                    overvoltage_trip,
  input  wire logic                    overcurrent_trip,
  input  wire logic                    power_fail_off,
  input  wire logic                    const_power_mode,
  input  wire logic                    overtemp_trip,
  input  wire logic                    master_slave_protect,
  input  wire logic                    external_pin_shutdown,
  input  wire logic [qsf_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [qsf_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [qsf_pkg::DATA_W-1:0] reg_rdata,
  output logic                         ques_summary,
  output logic                         irq
);

  logic [qsf_pkg::COND_W-1:0] cond_raw;
  logic [qsf_pkg::COND_W-1:0] sync1_q;
  logic [qsf_pkg::COND_W-1:0] cond_q;
  logic [qsf_pkg::COND_W-1:0] prev_q;
  logic [qsf_pkg::COND_W-1:0] falling_edge_mask_q;
  logic [qsf_pkg::COND_W-1:0] rising_edge_mask_q;
  logic [qsf_pkg::COND_W-1:0] enable_q;
  logic [qsf_pkg::COND_W-1:0] event_q;
  logic [qsf_pkg::COND_W-1:0] event_d;
  logic [qsf_pkg::COND_W-1:0] hit;
  logic [qsf_pkg::IRQ_W-1:0]  irq_st_q;
  logic [qsf_pkg::IRQ_W-1:0]  irq_msk_q;
  logic [qsf_pkg::IRQ_W-1:0]  irq_set;
  logic                       summary_d;
  logic                       wr_fall;
  logic                       wr_rise;
  logic                       wr_en;
  logic                       rd_event;
  logic [qsf_pkg::DATA_W-1:0] rdata_d;

  // Unused positions 6 to 8 are tied low so they can never produce an edge.
  always_comb
  begin
    cond_raw = '0;
    cond_raw[qsf_pkg::BIT_OVERVOLTAGE_TRIP]      = overvoltage_trip;
    cond_raw[qsf_pkg::BIT_OVERCURRENT_TRIP]      = overcurrent_trip;
    cond_raw[qsf_pkg::BIT_POWER_FAIL_OFF]        = power_fail_off;
    cond_raw[qsf_pkg::BIT_CONST_POWER_MODE]      = const_power_mode;
    cond_raw[qsf_pkg::BIT_OVERTEMP_TRIP]         = overtemp_trip;
    cond_raw[qsf_pkg::BIT_MASTER_SLAVE_PROTECT]  = master_slave_protect;
    cond_raw[qsf_pkg::BIT_EXTERNAL_PIN_SHUTDOWN] = external_pin_shutdown;
  end

  // Condition pins are asynchronous, so two flops precede edge detection.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_q <= qsf_pkg::RST_MASK;
      cond_q  <= qsf_pkg::RST_MASK;
      prev_q  <= qsf_pkg::RST_MASK;
    end
    else
    begin
      sync1_q <= cond_raw;
      cond_q  <= sync1_q;
      prev_q  <= cond_q;
    end
  end

  assign wr_fall  = reg_wr && (reg_addr == qsf_pkg::OFF_FALL);
  assign wr_rise  = reg_wr && (reg_addr == qsf_pkg::OFF_RISE);
  assign wr_en    = reg_wr && (reg_addr == qsf_pkg::OFF_ENABLE);
  assign rd_event = reg_rd && (reg_addr == qsf_pkg::OFF_EVENT);

  // Out-of-range bits are dropped rather than stored, which keeps reads honest.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      falling_edge_mask_q <= qsf_pkg::RST_MASK;
      rising_edge_mask_q  <= qsf_pkg::RST_MASK;
    end
    else
    begin
      if (wr_fall)
      begin
        falling_edge_mask_q <= reg_wdata[qsf_pkg::COND_W-1:0] & qsf_pkg::COND_MASK;
      end
      if (wr_rise)
      begin
        rising_edge_mask_q <= reg_wdata[qsf_pkg::COND_W-1:0] & qsf_pkg::COND_MASK;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      enable_q <= qsf_pkg::RST_MASK;
    end
    else if (reg_wr && (reg_addr == qsf_pkg::OFF_PRESET))
    begin
      enable_q <= qsf_pkg::RST_MASK;
    end
    else if (wr_en)
    begin
      enable_q <= reg_wdata[qsf_pkg::COND_W-1:0] & qsf_pkg::COND_MASK;
    end
  end

  // Each polarity filter is independent, so both masks set means any edge.
  always_comb
  begin
    hit = (falling_edge_mask_q & prev_q & ~cond_q)
        | (rising_edge_mask_q & ~prev_q & cond_q);
  end

  // A new edge in the same cycle as a clearing read survives the clear.
  always_comb
  begin
    event_d = rd_event ? hit : (event_q | hit);
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      event_q <= qsf_pkg::RST_MASK;
    end
    else
    begin
      event_q <= event_d;
    end
  end

  assign summary_d = |(event_d & enable_q);

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ques_summary <= 1'b0;
    end
    else
    begin
      ques_summary <= summary_d;
    end
  end

  always_comb
  begin
    irq_set = '0;
    irq_set[qsf_pkg::IRQ_BIT_EVENT]   = |hit;
    irq_set[qsf_pkg::IRQ_BIT_SUMMARY] = summary_d & ~ques_summary;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_st_q  <= qsf_pkg::RST_IRQ;
      irq_msk_q <= qsf_pkg::RST_IRQ;
    end
    else
    begin
      if (reg_wr && (reg_addr == qsf_pkg::OFF_IRQ_ST))
      begin
        irq_st_q <= (irq_st_q & ~reg_wdata[qsf_pkg::IRQ_W-1:0]) | irq_set;
      end
      else
      begin
        irq_st_q <= irq_st_q | irq_set;
      end
      if (reg_wr && (reg_addr == qsf_pkg::OFF_IRQ_MSK))
      begin
        irq_msk_q <= reg_wdata[qsf_pkg::IRQ_W-1:0];
      end
    end
  end

  // Irq follows the status one cycle late; a cleared bit drops irq a cycle after.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(irq_st_q & irq_msk_q);
    end
  end

  always_comb
  begin
    rdata_d = qsf_pkg::RST_DATA;
    unique case (reg_addr)
      qsf_pkg::OFF_COND:    rdata_d[qsf_pkg::COND_W-1:0] = cond_q;
      qsf_pkg::OFF_EVENT:   rdata_d[qsf_pkg::COND_W-1:0] = event_q;
      qsf_pkg::OFF_ENABLE:  rdata_d[qsf_pkg::COND_W-1:0] = enable_q;
      qsf_pkg::OFF_FALL:    rdata_d[qsf_pkg::COND_W-1:0] = falling_edge_mask_q;
      qsf_pkg::OFF_RISE:    rdata_d[qsf_pkg::COND_W-1:0] = rising_edge_mask_q;
      qsf_pkg::OFF_IRQ_ST:  rdata_d[qsf_pkg::IRQ_W-1:0]  = irq_st_q;
      qsf_pkg::OFF_IRQ_MSK: rdata_d[qsf_pkg::IRQ_W-1:0]  = irq_msk_q;
      default:              rdata_d = qsf_pkg::RST_DATA;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata <= qsf_pkg::RST_DATA;
    end
    else if (reg_rd)
    begin
      reg_rdata <= rdata_d;
    end
    else
    begin
      reg_rdata <= qsf_pkg::RST_DATA;
    end
  end

endmodule

// *** verification/qsf_filter_assertions.sv ***
`timescale 1ns/1ns
module qsf_chk
(
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        overvoltage_trip,
  input wire logic        overcurrent_trip,
  input wire logic        power_fail_off,
  input wire logic        const_power_mode,
  input wire logic        overtemp_trip,
  input wire logic        master_slave_protect,
  input wire logic        external_pin_shutdown,
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        ques_summary,
  input wire logic        irq
);
  logic [9:0] cond_p_q;
  logic [2:0] stab_q;
  wire logic [9:0] cond = {external_pin_shutdown, 3'h0, master_slave_protect, overtemp_trip,
    const_power_mode, power_fail_off, overcurrent_trip, overvoltage_trip};
  wire logic still = (cond == cond_p_q);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Quiet-cycle count, so checks skip the two-flop input pipeline.
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n) cond_p_q <= 10'h000;
    else cond_p_q <= cond;
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n) stab_q <= 3'h0;
    else stab_q <= !still ? 3'h0 : (stab_q == 3'h7 ? stab_q : stab_q + 3'h1);
  rst_out_a: assert property ($rose(rst_n) |-> !ques_summary && !irq && reg_rdata == 16'h0)
    else $error("outputs not clear after reset");
  mask_range_a: assert property (reg_rd && reg_addr inside {4'h2, 4'h3, 4'h4} |=>
    (reg_rdata & ~16'h023f) == 16'h0) else $error("mask holds a reserved bit");
  fall_back_a: assert property (reg_wr && reg_addr == 4'h3 ##1 reg_rd && reg_addr == 4'h3 |=>
    reg_rdata == ($past(reg_wdata, 2) & 16'h023f)) else $error("falling mask readback");
  rise_back_a: assert property (reg_wr && reg_addr == 4'h4 ##1 reg_rd && reg_addr == 4'h4 |=>
    reg_rdata == ($past(reg_wdata, 2) & 16'h023f)) else $error("rising mask readback");
  cond_map_a: assert property (reg_rd && reg_addr == 4'h0 && still && stab_q >= 3'h3 |=>
    reg_rdata == {6'h00, $past(cond)}) else $error("condition bit map");
  ev_clear_a: assert property (reg_rd && reg_addr == 4'h1 ##1 reg_rd && reg_addr == 4'h1 &&
    still && stab_q >= 3'h4 |=> reg_rdata == 16'h0) else $error("event read did not clear");
  preset_clr_a: assert property (reg_wr && reg_addr == 4'h5 ##1
    !(reg_wr && reg_addr == 4'h2) |=> !ques_summary) else $error("summary after preset");
  rd_idle_a: assert property (!reg_rd |=> reg_rdata == 16'h0)
    else $error("read data outside a read");
endmodule
bind qsf_filter qsf_chk qsf_chk_inst (.core_clk(core_clk), .rst_n(rst_n),
  .overvoltage_trip(overvoltage_trip), .overcurrent_trip(overcurrent_trip),
  .power_fail_off(power_fail_off), .const_power_mode(const_power_mode),
  .overtemp_trip(overtemp_trip), .master_slave_protect(master_slave_protect),
  .external_pin_shutdown(external_pin_shutdown), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ques_summary(ques_summary),
  .irq(irq));

// *** verification/tb.sv ***
`timescale 1ns/1ns
module tb;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [9:0]  pins = 10'h000;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic        ques_summary;
  logic        irq;
  int          errors = 0;
  int          comparisons = 0;
  int          cycles = 0;
  always #25 core_clk = ~core_clk;
  qsf_filter qsf_filter_inst (.core_clk(core_clk), .rst_n(rst_n), .overvoltage_trip(pins[0]),
    .overcurrent_trip(pins[1]), .power_fail_off(pins[2]), .const_power_mode(pins[3]),
    .overtemp_trip(pins[4]), .master_slave_protect(pins[5]), .external_pin_shutdown(pins[9]),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ques_summary(ques_summary), .irq(irq));
  task automatic report_and_stop();
    if (errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Optional write, then n back-to-back reads; only the last read is judged.
  task automatic acc(input logic [3:0] a, input logic [15:0] d, input logic [15:0] e,
                     input int w, input int n);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    if (w != 0)
    begin
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
    end
    if (n > 0)
    begin
      reg_rd <= 1'b1;
      repeat (n) @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, e);
    end
  endtask
  task automatic set_pins(input logic [9:0] v);
    @(posedge core_clk);
    pins <= v;
    repeat (5) @(posedge core_clk);
  endtask
  task automatic t_reset();
    for (int i = 0; i < 9; i++)
      if (i != 5) acc(4'(i), 16'h0, 16'h0, 0, 1);
    chk({14'h0, irq, ques_summary}, 16'h0);
  endtask
  task automatic t_masks();
    acc(4'h3, 16'hffff, 16'h023f, 1, 1);
    acc(4'h4, 16'h0155, 16'h0015, 1, 1);
    acc(4'h3, 16'h0240, 16'h0200, 1, 1);
    acc(4'h1, 16'h0, 16'h0, 0, 2);
    acc(4'hf, 16'hffff, 16'h0, 1, 1);
  endtask
  task automatic t_edge(input logic [15:0] f, input logic [15:0] r, input logic [15:0] er,
                        input logic [15:0] ef);
    acc(4'h3, f, 16'h0, 1, 0);
    acc(4'h4, r, 16'h0, 1, 0);
    set_pins(10'h23f);
    acc(4'h0, 16'h0, 16'h023f, 0, 1);
    acc(4'h1, 16'h0, er, 0, 1);
    set_pins(10'h000);
    acc(4'h1, 16'h0, ef, 0, 1);
  endtask
  task automatic t_summary();
    acc(4'h2, 16'h0001, 16'h0001, 1, 1);
    acc(4'h7, 16'h0003, 16'h0, 1, 0);
    acc(4'h4, 16'h0001, 16'h0, 1, 0);
    acc(4'h3, 16'h0000, 16'h0, 1, 0);
    set_pins(10'h001);
    chk({14'h0, irq, ques_summary}, 16'h3);
    acc(4'h6, 16'h0, 16'h0003, 0, 1);
    acc(4'h7, 16'h0000, 16'h0, 1, 0);
    repeat (2) @(posedge core_clk);
    chk({14'h0, irq, ques_summary}, 16'h1);
    acc(4'h1, 16'h0, 16'h0001, 0, 1);
    repeat (2) @(posedge core_clk);
    chk({14'h0, irq, ques_summary}, 16'h0);
    acc(4'h6, 16'h0003, 16'h0, 1, 1);
    set_pins(10'h000);
    set_pins(10'h001);
    chk({15'h0, ques_summary}, 16'h1);
    acc(4'h5, 16'h0000, 16'h0, 1, 0);
    repeat (2) @(posedge core_clk);
    chk({15'h0, ques_summary}, 16'h0);
    acc(4'h2, 16'h0, 16'h0, 0, 1);
  endtask
  initial
  begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_masks();
    t_edge(16'h0000, 16'h023f, 16'h023f, 16'h0000);
    t_edge(16'h023f, 16'h0000, 16'h0000, 16'h023f);
    t_edge(16'h023f, 16'h023f, 16'h023f, 16'h023f);
    t_edge(16'h0000, 16'h0000, 16'h0000, 16'h0000);
    t_edge(16'h0015, 16'h022a, 16'h022a, 16'h0015);
    t_summary();
    report_and_stop();
  end
  // A hang is cut at a ceiling well above the roughly two hundred cycles needed.
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      errors++;
      report_and_stop();
    end
  end
endmodule
